/* design/io_channel_top.sv */
// I/O module top: interrupts, unbuffered channel, arbiter and timer
module io_channel_top
  import io_module_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = io_module_pkg::TIMER_TICK_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [io_module_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic [io_module_pkg::IRQ_COUNT-1:0] irqLines,
  output logic progInterrupt,
  input wire logic [io_module_pkg::REQ_COUNT-1:0] memReq,
  output logic [io_module_pkg::REQ_COUNT-1:0] memGrant,
  output logic memCycleActive,
  output logic [io_module_pkg::MEM_ADDR_W-1:0] memAddr,
  output logic [io_module_pkg::WORD_W-1:0] outBus,
  output logic [1:0] pathSel,
  output logic selectStrobe,
  output logic dataStrobe,
  output logic chanBusy,
  input wire logic devReceived,
  input wire logic [io_module_pkg::DEV_ID_W-1:0] devIdCode,
  input wire logic [io_module_pkg::WORD_W-1:0] inBus
);

  localparam int unsigned SYNC_W = IRQ_COUNT + WORD_W + DEV_ID_W + 1;

  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  logic [SYNC_W-1:0] syncC;
  logic [SYNC_W-1:0] pinStable;
  logic [IRQ_COUNT-1:0] irqIn;
  logic [WORD_W-1:0] inWord;
  logic [DEV_ID_W-1:0] idIn;
  logic receivedIn;

  logic [IRQ_COUNT-1:0] irqStatus;
  logic [IRQ_COUNT-1:0] irqMask;
  logic [IRQ_COUNT-1:0] irqClear;
  chan_state_t state;
  logic [WORD_W-1:0] descriptor;
  logic [CNT_W-1:0] selTimer;
  logic [CNT_W-1:0] xferCnt;
  logic xferBusy;
  logic idError;
  logic noAnswer;
  logic timerDone;
  logic descAccept;
  logic dataAccept;
  logic wrDesc;
  logic wrData;
  logic wrTimer;
  logic [TIMER_W-1:0] timerCount;
  logic timerRun;
  logic timerDonePulse;
  logic [6:0] chanStatus;

  mem_arb_if arbBus ();

  // ===================================================================
  // Pin synchronisers
  assign pinRaw = {irqLines, inBus, devIdCode, devReceived};

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++)
    begin : gSync
      always_ff @(posedge sys_clk)
      begin
        if (!rst_b)
        begin
          syncA[g] <= 1'b0;
          syncB[g] <= 1'b0;
          syncC[g] <= 1'b0;
          pinStable[g] <= 1'b0;
        end
        else
        begin
          syncA[g] <= pinRaw[g];
          syncB[g] <= syncA[g];
          syncC[g] <= syncB[g];
          if (syncB[g] == syncC[g])
          begin
            pinStable[g] <= syncC[g];
          end
        end
      end
    end
  endgenerate

  assign receivedIn = pinStable[0];
  assign idIn = pinStable[DEV_ID_W:1];
  assign inWord = pinStable[DEV_ID_W+WORD_W:DEV_ID_W+1];
  assign irqIn = pinStable[SYNC_W-1:DEV_ID_W+WORD_W+1];

  // ===================================================================
  // Write decode
  assign wrDesc = regWr && (regAddr == DESCRIPTOR_OFS);
  assign wrData = regWr && (regAddr == DATA_OFS);
  assign wrTimer = regWr && (regAddr == TIMER_OFS);
  assign descAccept = wrDesc && !chanBusy
    && (regWrData[31:OPCODE_LSB] == DESC_OPCODE); // see (RQ7) (RQ18)
  assign dataAccept = wrData && (state == CH_READY) && !xferBusy; // see (RQ14) (RQ16)

  always_comb
  begin
    irqClear = '0;
    if (regWr && (regAddr == IRQ_STATUS_OFS))
    begin
      irqClear = regWrData[IRQ_COUNT-1:0]; // see (RQ6)
    end
    else if (regRd && (regAddr == IRQ_TAKE_OFS))
    begin
      irqClear = '1; // see (RQ6)
    end
  end

  // ===================================================================
  // Interrupt register and mask
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      irqStatus <= '0;
    end
    else
    begin
      irqStatus <= (irqStatus & ~irqClear) | irqIn; // see (RQ2) (RQ3) (RQ19)
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      irqMask <= IRQ_MASK_RESET;
    end
    else if (regWr && (regAddr == IRQ_MASK_OFS))
    begin
      irqMask <= regWrData[IRQ_COUNT-1:0]; // see (RQ5)
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      progInterrupt <= 1'b0;
    end
    else
    begin
      progInterrupt <= |(irqStatus & irqMask); // see (RQ4)
    end
  end

  // ===================================================================
  // Channel selection sequence
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state <= CH_IDLE;
      descriptor <= '0;
      pathSel <= 2'd0;
      selTimer <= '0;
      idError <= 1'b0;
      noAnswer <= 1'b0;
    end
    else
    begin
      if (regWr && (regAddr == CHAN_STATUS_OFS))
      begin
        if (regWrData[ST_ID_ERROR])
        begin
          idError <= 1'b0;
        end
        if (regWrData[ST_NO_ANSWER])
        begin
          noAnswer <= 1'b0;
        end
      end
      case (state)
        CH_IDLE, CH_READY:
        begin
          if (descAccept)
          begin
            descriptor <= regWrData[WORD_W-1:0];
            pathSel <= regWrData[PATH_LSB+1:PATH_LSB]; // see (RQ18)
            selTimer <= CNT_W'(SEL_TIMEOUT_CYCLES - 1);
            state <= CH_SELECT;
          end
        end
        CH_SELECT:
        begin
          if (receivedIn)
          begin
            state <= CH_CHECK; // see (RQ11)
          end
          else if (selTimer == '0)
          begin
            noAnswer <= 1'b1;
            state <= CH_IDLE;
          end
          else
          begin
            selTimer <= selTimer - 1'b1;
          end
        end
        CH_CHECK:
        begin
          if (idIn == descriptor[DEV_FIELD_LSB+DEV_ID_W-1:DEV_FIELD_LSB])
          begin
            state <= CH_READY; // see (RQ12) (RQ13)
          end
          else
          begin
            idError <= 1'b1; // see (RQ12)
            state <= CH_IDLE;
          end
        end
        default:
        begin
          state <= CH_IDLE;
        end
      endcase
    end
  end

  assign chanBusy = (state == CH_SELECT) || (state == CH_CHECK); // see (RQ20)
  assign selectStrobe = (state == CH_SELECT); // see (RQ8) (RQ10)

  // ===================================================================
  // Shared output bus and paced data transfers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      outBus <= '0;
      dataStrobe <= 1'b0;
    end
    else
    begin
      dataStrobe <= dataAccept; // see (RQ14)
      if (descAccept || dataAccept)
      begin
        outBus <= regWrData[WORD_W-1:0]; // see (RQ9)
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      xferBusy <= 1'b0;
      xferCnt <= '0;
    end
    else if (dataAccept)
    begin
      xferBusy <= 1'b1;
      xferCnt <= CNT_W'(XFER_MIN_CYCLES - 2); // see (RQ16)
    end
    else if (xferBusy)
    begin
      if (xferCnt == '0)
      begin
        xferBusy <= 1'b0;
      end
      else
      begin
        xferCnt <= xferCnt - 1'b1;
      end
    end
  end

  // ===================================================================
  // Memory address register and arbiter
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      memAddr <= '0;
    end
    else if (regWr && (regAddr == MEM_ADDR_OFS))
    begin
      memAddr <= regWrData[MEM_ADDR_W-1:0]; // see (RQ17)
    end
  end

  assign arbBus.req = memReq;
  assign memGrant = arbBus.grant;
  assign memCycleActive = arbBus.busy;

  mem_arbiter uArbiter
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .port(arbBus.arb)
  );

  // ===================================================================
  // Interval timer
  interval_timer #(
    .TICK_CYCLES(MS_TICK_CYCLES)
  ) uTimer
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(wrTimer),
    .preset(regWrData[TIMER_W-1:0]),
    .count(timerCount),
    .running(timerRun),
    .done(timerDonePulse)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      timerDone <= 1'b0;
    end
    else if (timerDonePulse)
    begin
      timerDone <= 1'b1;
    end
    else if (regWr && (regAddr == CHAN_STATUS_OFS) && regWrData[ST_TIMER_DONE])
    begin
      timerDone <= 1'b0;
    end
  end

  // ===================================================================
  // Read port
  assign chanStatus = {timerDone, timerRun, xferBusy, noAnswer, idError,
    (state == CH_READY), chanBusy};

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || !regRd)
    begin
      regRdData <= 32'h0000_0000;
    end
    else if (regAddr == IRQ_STATUS_OFS || regAddr == IRQ_TAKE_OFS)
      regRdData <= {8'h00, irqStatus}; // see (RQ6)
    else if (regAddr == IRQ_MASK_OFS)
      regRdData <= {8'h00, irqMask};
    else if (regAddr == DESCRIPTOR_OFS)
      regRdData <= {4'h0, 2'b00, pathSel, descriptor};
    else if (regAddr == CHAN_STATUS_OFS)
      regRdData <= {25'h0, chanStatus};
    else if (regAddr == DATA_OFS)
      regRdData <= {8'h00, inWord};
    else if (regAddr == TIMER_OFS)
      regRdData <= {8'h00, timerCount};
    else if (regAddr == MEM_ADDR_OFS)
      regRdData <= {20'h00000, memAddr};
    else
      regRdData <= 32'h0000_0000;
  end

endmodule : io_channel_top

/* design/io_module_pkg.sv */
// Constants and state types of the I/O module channel
//=====================================================================
// Functional notes
// (RQ1) Memory requests granted in arrival order; processor request always wins.
// (RQ2) Twenty-four interrupt sources, one bit each in the interrupt register.
// (RQ3) An interrupt line sets its bit whatever the mask holds.
// (RQ4) Processor interrupt raised only by a set bit whose mask bit enables it.
// (RQ5) Software loads the interrupt mask ahead of time.
// (RQ6) Software reads and clears the interrupt register, separately or in one access.
// (RQ7) New descriptor accepted only while the channel is not busy.
// (RQ8) Select strobe stays high while the descriptor transfer is under way.
// (RQ9) Descriptor driven on the one shared 24-bit output bus.
// (RQ10) Peripherals sample the bus while the select strobe is high.
// (RQ11) The addressed peripheral answers with the received signal.
// (RQ12) Returned identification code is compared against the descriptor.
// (RQ13) Selection stays in force across transfers until a new descriptor.
// (RQ14) Data transfers only after selection, each started by a program write.
// (RQ15) Interval timer preset loaded by software, one millisecond per count.
// (RQ16) Unbuffered transfers paced to at most 125,000 words per second.
// (RQ17) Twelve-bit memory word address supplied from the address register.
// (RQ18) Descriptors arrive by operation code 06 and pick one of four paths.
// (RQ19) Interrupt bits stay set until software clears them.
// (RQ20) Busy from descriptor start until received and identity check complete.
package io_module_pkg;

  // ===================================================================
  // Timing
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned SYS_CLK_MHZ = SYS_CLK_HZ / 1_000_000;
  localparam int unsigned MEM_CYCLE_NS = 4000;
  localparam int unsigned MEM_CYCLE_CYCLES = (MEM_CYCLE_NS * SYS_CLK_MHZ) / 1000;
  localparam int unsigned XFER_RATE_WPS = 125_000;
  localparam int unsigned XFER_MIN_NS = 1_000_000_000 / XFER_RATE_WPS;
  localparam int unsigned XFER_MIN_CYCLES = (XFER_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned TIMER_LSB_MS = 1;
  localparam int unsigned TIMER_TICK_CYCLES = (SYS_CLK_HZ / 1000) * TIMER_LSB_MS;
  localparam int unsigned SEL_TIMEOUT_US = 100;
  localparam int unsigned SEL_TIMEOUT_CYCLES = SEL_TIMEOUT_US * SYS_CLK_MHZ;

  // ===================================================================
  // Widths
  localparam int unsigned IRQ_COUNT = 24;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned MEM_ADDR_W = 12;
  localparam int unsigned REQ_COUNT = 4;
  localparam int unsigned DEV_ID_W = 6;
  localparam int unsigned TIMER_W = 24;
  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned CNT_W = 12;

  // ===================================================================
  // Register map
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h00;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h04;
  localparam logic [7:0] IRQ_TAKE_OFS = 8'h08;
  localparam logic [7:0] DESCRIPTOR_OFS = 8'h0C;
  localparam logic [7:0] CHAN_STATUS_OFS = 8'h10;
  localparam logic [7:0] DATA_OFS = 8'h14;
  localparam logic [7:0] TIMER_OFS = 8'h18;
  localparam logic [7:0] MEM_ADDR_OFS = 8'h1C;

  // Descriptor write word fields
  localparam int unsigned OPCODE_LSB = 26;
  localparam logic [5:0] DESC_OPCODE = 6'h06;
  localparam int unsigned PATH_LSB = 24;
  localparam int unsigned DEV_FIELD_LSB = 18;

  // Channel status bits
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_SELECTED = 1;
  localparam int unsigned ST_ID_ERROR = 2;
  localparam int unsigned ST_NO_ANSWER = 3;
  localparam int unsigned ST_XFER_BUSY = 4;
  localparam int unsigned ST_TIMER_RUN = 5;
  localparam int unsigned ST_TIMER_DONE = 6;

  localparam logic [23:0] IRQ_MASK_RESET = 24'h000000;

  typedef enum logic [1:0]
  {
    CH_IDLE = 2'b00,
    CH_SELECT = 2'b01,
    CH_CHECK = 2'b11,
    CH_READY = 2'b10
  } chan_state_t;

endpackage : io_module_pkg

/* design/mem_arb_if.sv */
// Request and grant lines between the channel top and the memory arbiter
interface mem_arb_if;
  logic [3:0] req;
  logic [3:0] grant;
  logic busy;

  modport arb
  (
    input req,
    output grant,
    output busy
  );

  modport user
  (
    output req,
    input grant,
    input busy
  );
endinterface : mem_arb_if

/* design/mem_arbiter.sv */
// Memory access arbiter: arrival order with processor priority
module mem_arbiter
  import io_module_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  mem_arb_if.arb port
);

  logic [3:0] pend;
  logic [1:0] rank [4];
  logic [CNT_W-1:0] cycleCnt;
  logic [3:0] next_pend;
  logic [1:0] next_rank [4];
  logic [1:0] pick;
  logic doGrant;
  logic [2:0] cnt;

  // ===================================================================
  // Queue update
  always_comb
  begin
    next_pend = pend;
    next_rank = rank;
    pick = 2'd0;
    doGrant = !port.busy && (|pend);
    if (!pend[0]) // see (RQ1)
    begin
      for (int i = 1; i < 4; i++)
      begin
        if (pend[i] && rank[i] == 2'd0)
        begin
          pick = 2'(i); // see (RQ1)
        end
      end
    end
    if (doGrant)
    begin
      next_pend[pick] = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        if (pend[i] && rank[i] > rank[pick])
        begin
          next_rank[i] = rank[i] - 2'd1;
        end
      end
    end
    cnt = 3'($countones(next_pend));
    for (int i = 0; i < 4; i++)
    begin
      if (port.req[i] && !pend[i])
      begin
        next_pend[i] = 1'b1;
        next_rank[i] = cnt[1:0]; // see (RQ1)
        cnt = cnt + 3'd1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      pend <= 4'h0;
      rank <= '{default: 2'd0};
    end
    else
    begin
      pend <= next_pend;
      rank <= next_rank;
    end
  end

  // ===================================================================
  // Grant pulse and memory cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      port.grant <= 4'h0;
      port.busy <= 1'b0;
      cycleCnt <= '0;
    end
    else
    begin
      port.grant <= 4'h0;
      if (doGrant)
      begin
        port.grant <= 4'h1 << pick;
        port.busy <= 1'b1;
        cycleCnt <= CNT_W'(MEM_CYCLE_CYCLES - 1);
      end
      else if (port.busy)
      begin
        if (cycleCnt == '0)
        begin
          port.busy <= 1'b0;
        end
        else
        begin
          cycleCnt <= cycleCnt - 1'b1;
        end
      end
    end
  end

endmodule : mem_arbiter

/* design/interval_timer.sv */
// Interval timer counting down a software preset in millisecond steps
module interval_timer
  import io_module_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TIMER_TICK_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [io_module_pkg::TIMER_W-1:0] preset,
  output logic [io_module_pkg::TIMER_W-1:0] count,
  output logic running,
  output logic done
);

  logic [31:0] divCnt;
  logic msTick;

  // ===================================================================
  // Millisecond enable
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || load)
    begin
      divCnt <= 32'h0;
      msTick <= 1'b0;
    end
    else if (divCnt == TICK_CYCLES - 1)
    begin
      divCnt <= 32'h0;
      msTick <= 1'b1;
    end
    else
    begin
      divCnt <= divCnt + 32'h1;
      msTick <= 1'b0;
    end
  end

  // ===================================================================
  // Countdown
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (load)
      begin
        count <= preset; // see (RQ15)
        running <= (preset != '0);
      end
      else if (running && msTick)
      begin
        count <= count - 1'b1;
        if (count == TIMER_W'(1))
        begin
          running <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule : interval_timer

/* testbench/io_channel_checker.sv */
// Port-level assertions for the I/O channel top, bound to it
module io_channel_checker
  import io_module_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic [3:0] memReq,
  input wire logic [3:0] memGrant,
  input wire logic memCycleActive,
  input wire logic [23:0] outBus,
  input wire logic selectStrobe,
  input wire logic dataStrobe,
  input wire logic chanBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  int unsigned gapCnt, busyCnt, actCnt;
  // ==================================================================
  // Helper counters
  always_ff @(posedge sys_clk)
  begin
    gapCnt <= !rst_b ? 1000 : dataStrobe ? 1 : (gapCnt < 1000) ? gapCnt + 1 : gapCnt;
    busyCnt <= (!rst_b || !chanBusy) ? 0 : busyCnt + 1;
    actCnt <= (!rst_b || !memCycleActive) ? 0 : actCnt + 1;
  end
  // ==================================================================
  // Assertions
  grant_onehot_a: assert property ($onehot0(memGrant))
    else $error("memory grant not one-hot");
  grant_cycle_a: assert property (|memGrant |-> memCycleActive ##1
    (memCycleActive && memGrant == 4'h0)) else $error("grant without memory cycle");
  proc_first_a: assert property (memReq == 4'h1 && $past(memReq) == 4'h0
    && !memCycleActive |-> ##[1:2] memGrant[0]) else $error("processor grant late");
  cycle_len_a: assert property ($fell(memCycleActive) |-> actCnt == MEM_CYCLE_CYCLES)
    else $error("memory cycle length wrong");
  sel_cause_a: assert property ($rose(selectStrobe) |-> $past(regWr && !chanBusy
    && regAddr == DESCRIPTOR_OFS && regWrData[31:26] == DESC_OPCODE)
    && outBus == $past(regWrData[23:0])) else $error("select strobe without descriptor");
  sel_hold_a: assert property (selectStrobe && $past(selectStrobe)
    |-> chanBusy && $stable(outBus)) else $error("bus moved during selection");
  data_cause_a: assert property (dataStrobe |-> !chanBusy && $past(regWr)
    && $past(regAddr) == DATA_OFS && outBus == $past(regWrData[23:0]))
    else $error("data strobe without data write");
  data_gap_a: assert property (dataStrobe |-> gapCnt >= XFER_MIN_CYCLES)
    else $error("data words too close");
  busy_bound_a: assert property (busyCnt <= SEL_TIMEOUT_CYCLES + 8)
    else $error("channel busy too long");
  rd_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside read slot");
endmodule : io_channel_checker

bind io_channel_top io_channel_checker chk_u
(
  .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .memReq(memReq),
  .memGrant(memGrant), .memCycleActive(memCycleActive), .outBus(outBus),
  .selectStrobe(selectStrobe), .dataStrobe(dataStrobe), .chanBusy(chanBusy)
);

/* testbench/periph_model.sv */
// Behavioural peripheral on the shared output bus
module periph_model
(
  input wire logic sys_clk,
  input wire logic selectStrobe,
  input wire logic [23:0] outBus,
  input wire logic [5:0] myId,
  input wire logic [3:0] delay,
  input wire logic wrongId,
  output logic devReceived,
  output logic [5:0] devIdCode,
  output logic [23:0] inBus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitCnt = 4'h0;
  initial
  begin
    devReceived = 1'b0;
    devIdCode = 6'h15;
    inBus = 24'h3C3C3C;
  end
  // Released lines toggle so a stale value is never mistaken for an answer
  always @(posedge sys_clk)
  begin
    inBus <= ~inBus;
    if (selectStrobe && outBus[23:18] == myId)
    begin
      if (waitCnt == delay)
      begin
        devReceived <= 1'b1;
        devIdCode <= wrongId ? ~myId : myId;
      end
      else
        waitCnt <= waitCnt + 4'h1;
    end
    else
    begin
      waitCnt <= 4'h0;
      devReceived <= 1'b0;
      devIdCode <= ~devIdCode;
    end
  end
endmodule : periph_model

/* testbench/tb_io_module_channel_and_interrupts.sv */
// Self-checking bench for interrupts, channel, timer and arbiter
module tb_io_module_channel_and_interrupts;
  import io_module_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [23:0] irqLines = 24'h0;
  logic [3:0] memReq = 4'h0;
  logic [5:0] devId = 6'h00;
  logic [3:0] delay = 4'h2;
  logic wrongId = 1'b0;
  logic [31:0] regRdData, q, d;
  logic [23:0] outBus, inBus, p, m;
  logic [11:0] memAddr;
  logic [5:0] devIdCode;
  logic [3:0] memGrant;
  logic [1:0] pathSel;
  logic progInterrupt, memCycleActive, selectStrobe, dataStrobe, chanBusy, devReceived;
  logic [3:0] grants[$];
  logic [3:0] expGr[7] = '{4'h2, 4'h1, 4'h8, 4'h4, 4'h2, 4'h4, 4'h1};
  int errCount = 0;
  int checked = 0;

  io_channel_top #(.MS_TICK_CYCLES(10)) dut_u
  (
    .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irqLines(irqLines),
    .progInterrupt(progInterrupt), .memReq(memReq), .memGrant(memGrant),
    .memCycleActive(memCycleActive), .memAddr(memAddr), .outBus(outBus),
    .pathSel(pathSel), .selectStrobe(selectStrobe), .dataStrobe(dataStrobe),
    .chanBusy(chanBusy), .devReceived(devReceived), .devIdCode(devIdCode), .inBus(inBus)
  );
  periph_model per_u
  (
    .sys_clk(sys_clk), .selectStrobe(selectStrobe), .outBus(outBus), .myId(devId),
    .delay(delay), .wrongId(wrongId), .devReceived(devReceived),
    .devIdCode(devIdCode), .inBus(inBus)
  );

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (|memGrant)
      grants.push_back(memGrant);
  end

  // ==================================================================
  // Tasks and expectation helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    q = regRdData;
  endtask : rd
  task automatic req(input logic [3:0] v);
    @(posedge sys_clk);
    memReq <= v;
    @(posedge sys_clk);
    memReq <= 4'h0;
  endtask : req
  task automatic waitIdle();
    for (int i = 0; i < 5000 && chanBusy; i++)
      tick(1);
  endtask : waitIdle
  function automatic logic [31:0] desc(input logic [1:0] pa, input logic [5:0] id);
    return {DESC_OPCODE, pa, id, 18'($urandom)};
  endfunction : desc
  function automatic logic [31:0] bitv(input int b);
    return 32'h1 << b;
  endfunction : bitv
  task automatic finalReport();
    $display("comparisons %0d, mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finalReport

  initial
  begin
    #500000;
    errCount++;
    finalReport();
  end

  // ==================================================================
  // Main sequence
  initial
  begin
    void'($urandom(66));
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(IRQ_MASK_OFS);
    chk("mask reset", q, {8'h0, IRQ_MASK_RESET});
    rd(8'hFC);
    chk("unmapped read", q, 32'h0);
    d = $urandom;
    wr(MEM_ADDR_OFS, {20'h0, d[11:0]});
    chk("memAddr", {20'h0, memAddr}, {20'h0, d[11:0]});
    rd(MEM_ADDR_OFS);
    chk("address readback", q, {20'h0, d[11:0]});
    for (int i = 0; i < 24; i++)
    begin
      @(posedge sys_clk) irqLines <= 24'h1 << i;
      tick(6);
      irqLines <= 24'h0;
      tick(6);
      chk("masked interrupt", {31'h0, progInterrupt}, 32'h0);
      rd(IRQ_TAKE_OFS);
      chk("take", q, bitv(i));
      rd(IRQ_STATUS_OFS);
      chk("status after take", q, 32'h0);
    end
    p = 24'($urandom) | 24'h1;
    m = p & (~p + 24'h1);
    @(posedge sys_clk) irqLines <= p;
    tick(6);
    irqLines <= 24'h0;
    tick(8);
    rd(IRQ_STATUS_OFS);
    chk("sticky status", q, {8'h0, p});
    wr(IRQ_MASK_OFS, {8'h0, m});
    tick(2);
    chk("unmasked interrupt", {31'h0, progInterrupt}, 32'h1);
    wr(IRQ_STATUS_OFS, {8'h0, m});
    tick(2);
    chk("cleared interrupt", {31'h0, progInterrupt}, 32'h0);
    rd(IRQ_STATUS_OFS);
    chk("partial clear", q, {8'h0, p & ~m});
    devId <= 6'($urandom);
    wr(DESCRIPTOR_OFS, desc(2'h1, devId) ^ 32'h0400_0000);
    chk("bad opcode", {31'h0, selectStrobe}, 32'h0);
    for (int pa = 0; pa < 4; pa++)
    begin
      delay <= 4'($urandom);
      d = desc(2'(pa), devId);
      wr(DESCRIPTOR_OFS, d);
      chk("strobe", {31'h0, selectStrobe & chanBusy}, 32'h1);
      chk("descriptor bus", {8'h0, outBus}, {8'h0, d[23:0]});
      chk("path", {30'h0, pathSel}, pa);
      wr(DESCRIPTOR_OFS, desc(2'(pa), devId));
      chk("busy refusal", {8'h0, outBus}, {8'h0, d[23:0]});
      waitIdle();
      rd(CHAN_STATUS_OFS);
      chk("selected", q, bitv(ST_SELECTED));
    end
    d = $urandom;
    wr(DATA_OFS, d);
    chk("data strobe", {31'h0, dataStrobe}, 32'h1);
    chk("data word", {8'h0, outBus}, {8'h0, d[23:0]});
    wr(DATA_OFS, ~d);
    chk("early data dropped", {8'h0, outBus}, {8'h0, d[23:0]});
    tick(320);
    d = $urandom;
    wr(DATA_OFS, d);
    chk("second word", {8'h0, outBus}, {8'h0, d[23:0]});
    tick(320);
    wrongId <= 1'b1;
    wr(DESCRIPTOR_OFS, desc(2'h2, devId));
    waitIdle();
    rd(CHAN_STATUS_OFS);
    chk("identity error", q, bitv(ST_ID_ERROR));
    wr(DATA_OFS, $urandom);
    chk("data unselected", {31'h0, dataStrobe}, 32'h0);
    wrongId <= 1'b0;
    wr(CHAN_STATUS_OFS, bitv(ST_ID_ERROR));
    wr(DESCRIPTOR_OFS, desc(2'h3, ~devId));
    waitIdle();
    rd(CHAN_STATUS_OFS);
    chk("no answer", q, bitv(ST_NO_ANSWER));
    wr(CHAN_STATUS_OFS, bitv(ST_NO_ANSWER));
    wr(TIMER_OFS, 32'h3);
    rd(TIMER_OFS);
    chk("timer preset", q, 32'h3);
    rd(CHAN_STATUS_OFS);
    chk("timer running", {31'h0, q[ST_TIMER_RUN]}, 32'h1);
    tick(10);
    rd(CHAN_STATUS_OFS);
    chk("timer early", {31'h0, q[ST_TIMER_DONE]}, 32'h0);
    tick(30);
    rd(CHAN_STATUS_OFS);
    chk("timer done", {31'h0, q[ST_TIMER_DONE]}, 32'h1);
    req(4'h2);
    tick(5);
    req(4'h8);
    req(4'h4);
    req(4'h1);
    tick(700);
    req(4'h6);
    tick(400);
    req(4'h1);
    tick(20);
    chk("grant count", grants.size(), 7);
    foreach (expGr[i])
      chk("grant order", {28'h0, grants[i]}, {28'h0, expGr[i]});
    finalReport();
  end
endmodule : tb_io_module_channel_and_interrupts
